// ===== design/uhcc_defines.svh
// constants for the usb host command controls block
// assumes a 20 MHz system clock and a byte-addressed register port
`ifndef UHCC_DEFINES_SVH
`define UHCC_DEFINES_SVH

// ==========================================================
// register map
`define UHCC_CMD_OFFSET 8'h20
`define UHCC_ADDR_W 8

// ==========================================================
// field positions of usb_host_command
`define UHCC_ITC_MSB 23
`define UHCC_ITC_LSB 16
`define UHCC_LIGHT_CONTROLLER_RESET_BIT 7
`define UHCC_ASYNC_ADVANCE_DOORBELL_BIT 6

// ==========================================================
// reset values and threshold codes
`define UHCC_ITC_RESET 8'h08
`define UHCC_ITC_1 8'h01
`define UHCC_ITC_2 8'h02
`define UHCC_ITC_4 8'h04
`define UHCC_ITC_8 8'h08
`define UHCC_ITC_16 8'h10
`define UHCC_ITC_32 8'h20
`define UHCC_ITC_64 8'h40

// ==========================================================
// timing
`define UHCC_CLK_PERIOD_NS 50
`define UHCC_LIGHT_CONTROLLER_RESET_TIME_NS 1000
`define UHCC_LIGHT_CONTROLLER_RESET_CYCLES \
  ((`UHCC_LIGHT_CONTROLLER_RESET_TIME_NS + `UHCC_CLK_PERIOD_NS - 1) / `UHCC_CLK_PERIOD_NS)

`endif

// ===== design/uhcc_pkg.sv
// types for the usb host command controls block
// assumes uhcc_defines.svh is on the include path
`default_nettype none

package uhcc_pkg;

  // ==========================================================
  // light reset sequencer states, gray from idle through busy to done
  typedef enum logic [1:0] {
    UHCC_LR_IDLE = 2'h0,
    UHCC_LR_BUSY = 2'h1,
    UHCC_LR_DONE = 2'h3
  } uhcc_lr_state_t;

  typedef logic [7:0] uhcc_itc_t;

endpackage : uhcc_pkg

`default_nettype wire

// ===== design/uhcc_thr_if.sv
// carrier between the command block and its threshold timer
// assumes both ends share sys_clk
`timescale 1ns/1ps
`default_nettype none

interface uhcc_thr_if;
  logic uframeTick;
  logic [7:0] thresholdCode;
  logic restart;
  logic boundary;

  modport ctrl (output uframeTick, output thresholdCode, output restart,
    input boundary);
  modport timer (input uframeTick, input thresholdCode, input restart,
    output boundary);
endinterface : uhcc_thr_if

`default_nettype wire

// ===== design/uhcc_thr_timer.sv
// interrupt threshold timer: pulses at each threshold boundary
// assumes one uframeTick pulse per micro frame
`timescale 1ns/1ps
`default_nettype none
`include "uhcc_defines.svh"

module uhcc_thr_timer
  import uhcc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // link to command block
  uhcc_thr_if.timer thr
);

  logic [CNT_W-1:0] frameCnt_reg;
  logic [CNT_W-1:0] limit;
  logic hit;

  // ==========================================================
  // code to micro frame count
  // undefined codes fall back to eight frames, the reset choice
  always_comb begin
    case (thr.thresholdCode)
      `UHCC_ITC_1: limit = CNT_W'(1);
      `UHCC_ITC_2: limit = CNT_W'(2);
      `UHCC_ITC_4: limit = CNT_W'(4);
      `UHCC_ITC_8: limit = CNT_W'(8);
      `UHCC_ITC_16: limit = CNT_W'(16);
      `UHCC_ITC_32: limit = CNT_W'(32);
      `UHCC_ITC_64: limit = CNT_W'(64);
      default: limit = CNT_W'(8);
    endcase
  end

  assign hit = thr.uframeTick && (frameCnt_reg >= limit - CNT_W'(1));

  // ==========================================================
  // micro frame counter
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      frameCnt_reg <= '0;
    end else if (thr.restart || hit) begin
      frameCnt_reg <= '0;
    end else if (thr.uframeTick) begin
      frameCnt_reg <= frameCnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      thr.boundary <= 1'b0;
    end else begin
      thr.boundary <= hit && !thr.restart;
    end
  end

endmodule : uhcc_thr_timer

`default_nettype wire

// ===== design/uhcc_cmd.sv
// command register controls: threshold, light reset, doorbell
// assumes a simple register port and the schedule engine on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "uhcc_defines.svh"

module uhcc_cmd
  import uhcc_pkg::*;
#(
  parameter bit LIGHT_RESET_IMPL = 1'b1,
  parameter int LIGHT_CONTROLLER_RESET_CYCLES = `UHCC_LIGHT_CONTROLLER_RESET_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [`UHCC_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  // status and enable links
  input wire logic controllerHaltedFlag,
  input wire logic asyncAdvanceIrqEnable,
  input wire logic asyncAdvanceStatusClr,
  output logic asyncAdvanceStatus,
  // schedule engine
  input wire logic uframeTick,
  input wire logic scheduleEvictDone,
  output logic doorbellRequest,
  output logic lightResetActive,
  // interrupt
  output logic asyncAdvanceIrq
);

  logic rstSync1_reg;
  logic rstN;
  logic cmdWrite;
  logic cmdRead;
  logic lightStart;
  logic lightEnd;
  uhcc_itc_t itc_reg;
  logic doorbell_reg;
  logic pending_reg;
  logic [15:0] lrCnt_reg;
  uhcc_lr_state_t lrState_reg;
  uhcc_lr_state_t lrState_next;

  uhcc_thr_if thr ();

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN <= rstSync1_reg;
    end
  end

  assign cmdWrite = regWrEn && (regAddr == `UHCC_CMD_OFFSET);
  assign cmdRead = regRdEn && (regAddr == `UHCC_CMD_OFFSET);
  assign lightStart = LIGHT_RESET_IMPL && cmdWrite &&
    regWrData[`UHCC_LIGHT_CONTROLLER_RESET_BIT] && (lrState_reg == UHCC_LR_IDLE);
  assign lightEnd = (lrState_reg == UHCC_LR_DONE);

  // ==========================================================
  // light reset sequencer
  always_comb begin
    case (lrState_reg)
      UHCC_LR_IDLE: lrState_next = lightStart ? UHCC_LR_BUSY : UHCC_LR_IDLE;
      UHCC_LR_BUSY: lrState_next =
        (lrCnt_reg >= 16'(LIGHT_CONTROLLER_RESET_CYCLES - 1)) ? UHCC_LR_DONE : UHCC_LR_BUSY;
      UHCC_LR_DONE: lrState_next = UHCC_LR_IDLE;
      default: lrState_next = UHCC_LR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      lrState_reg <= UHCC_LR_IDLE;
    end else begin
      lrState_reg <= lrState_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      lrCnt_reg <= '0;
    end else if (lrState_reg == UHCC_LR_BUSY) begin
      lrCnt_reg <= lrCnt_reg + 16'h0001;
    end else begin
      lrCnt_reg <= '0;
    end
  end

  // only controller state is cleared; port state lives elsewhere
  assign lightResetActive = (lrState_reg != UHCC_LR_IDLE);

  // ==========================================================
  // threshold field
  // writes while running are dropped: the effect is undefined anyway
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      itc_reg <= `UHCC_ITC_RESET;
    end else if (lightEnd) begin
      itc_reg <= `UHCC_ITC_RESET;
    end else if (cmdWrite && controllerHaltedFlag) begin
      itc_reg <= regWrData[`UHCC_ITC_MSB:`UHCC_ITC_LSB];
    end
  end

  // ==========================================================
  // doorbell and async advance status
  // pending drives the engine; the visible bit stays set afterwards
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pending_reg <= 1'b0;
    end else if (lightResetActive) begin
      pending_reg <= 1'b0;
    end else if (cmdWrite && regWrData[`UHCC_ASYNC_ADVANCE_DOORBELL_BIT]) begin
      pending_reg <= 1'b1;
    end else if (scheduleEvictDone) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      doorbell_reg <= 1'b0;
    end else if (lightResetActive) begin
      doorbell_reg <= 1'b0;
    end else if (pending_reg && scheduleEvictDone) begin
      doorbell_reg <= 1'b1;
    end else if (cmdWrite) begin
      doorbell_reg <= regWrData[`UHCC_ASYNC_ADVANCE_DOORBELL_BIT];
    end
  end

  assign doorbellRequest = pending_reg;

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      asyncAdvanceStatus <= 1'b0;
    end else if (pending_reg && scheduleEvictDone) begin
      asyncAdvanceStatus <= 1'b1;
    end else if (asyncAdvanceStatusClr || lightResetActive) begin
      asyncAdvanceStatus <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt at the threshold boundary
  assign thr.uframeTick = uframeTick;
  assign thr.thresholdCode = itc_reg;
  assign thr.restart = lightResetActive;

  uhcc_thr_timer #(
    .CNT_W(7)
  ) thrTimer (
    .clk(sys_clk),
    .rstN(rstN),
    .thr(thr)
  );

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      asyncAdvanceIrq <= 1'b0;
    end else if (!asyncAdvanceStatus || !asyncAdvanceIrqEnable) begin
      asyncAdvanceIrq <= 1'b0;
    end else if (thr.boundary) begin
      asyncAdvanceIrq <= 1'b1;
    end
  end

  // ==========================================================
  // read path; unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= '0;
    end else if (cmdRead) begin
      regRdData <= '0;
      regRdData[`UHCC_ITC_MSB:`UHCC_ITC_LSB] <= itc_reg;
      regRdData[`UHCC_LIGHT_CONTROLLER_RESET_BIT] <=
        LIGHT_RESET_IMPL && lightResetActive;
      regRdData[`UHCC_ASYNC_ADVANCE_DOORBELL_BIT] <= doorbell_reg;
    end else if (regRdEn) begin
      regRdData <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
    end
  end

endmodule : uhcc_cmd

`default_nettype wire

// ===== verif/uhcc_cmd_chk.sv
// checker for the usb host command controls block
// assumes it is bound onto uhcc_cmd and sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "uhcc_defines.svh"

module uhcc_cmd_chk #(
  parameter bit LIGHT_RESET_IMPL = 1'b1,
  parameter int LIGHT_CONTROLLER_RESET_CYCLES = `UHCC_LIGHT_CONTROLLER_RESET_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid,
  // links
  input wire logic controllerHaltedFlag,
  input wire logic asyncAdvanceIrqEnable,
  input wire logic asyncAdvanceStatusClr,
  input wire logic asyncAdvanceStatus,
  input wire logic uframeTick,
  input wire logic scheduleEvictDone,
  input wire logic doorbellRequest,
  input wire logic lightResetActive,
  input wire logic asyncAdvanceIrq
);
  // ==========================================================
  // helper: length of the light reset run
  logic [7:0] lrCnt_reg;
  logic cmdWr;
  assign cmdWr = regWrEn && regAddr == `UHCC_CMD_OFFSET;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) lrCnt_reg <= 8'h00;
    else if (lightResetActive) lrCnt_reg <= lrCnt_reg + 8'h01;
    else lrCnt_reg <= 8'h00;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (regRdEn |=> regRdValid)
    else $error("read not answered next cycle");
  rd_reserved_a: assert property (regRdValid |->
    regRdData[31:24] == 8'h00 && regRdData[15:8] == 8'h00 &&
    regRdData[5:0] == 6'h00) else $error("reserved bits read nonzero");
  lr_bit_a: assert property (regRdValid && !$past(lightResetActive)
    |-> !regRdData[7]) else $error("light reset bit reads one when idle");
  lr_start_a: assert property (cmdWr && regWrData[7] && LIGHT_RESET_IMPL
    |=> lightResetActive) else $error("light reset did not start");
  lr_length_a: assert property ($fell(lightResetActive)
    |-> lrCnt_reg == 8'(LIGHT_CONTROLLER_RESET_CYCLES + 1)) else $error("light reset length");
  bell_req_a: assert property (cmdWr && regWrData[6] && !regWrData[7] &&
    !lightResetActive |=> doorbellRequest) else $error("doorbell not raised");
  status_set_a: assert property (doorbellRequest && scheduleEvictDone &&
    !regWrEn && !lightResetActive |=> asyncAdvanceStatus && !doorbellRequest)
    else $error("status not set after eviction");
  status_cause_a: assert property ($rose(asyncAdvanceStatus)
    |-> $past(doorbellRequest && scheduleEvictDone)) else $error("stray status");
  irq_cause_a: assert property ($rose(asyncAdvanceIrq) |->
    $past(asyncAdvanceStatus && asyncAdvanceIrqEnable) && $past(uframeTick, 2))
    else $error("interrupt off boundary");
  irq_drop_a: assert property (!(asyncAdvanceStatus && asyncAdvanceIrqEnable)
    |=> !asyncAdvanceIrq) else $error("interrupt did not drop");
  c_irq: cover property ($rose(asyncAdvanceIrq));
  c_lr: cover property ($fell(lightResetActive));
  c_bell: cover property ($rose(asyncAdvanceStatus));
endmodule : uhcc_cmd_chk

bind uhcc_cmd uhcc_cmd_chk #(.LIGHT_RESET_IMPL(LIGHT_RESET_IMPL),
  .LIGHT_CONTROLLER_RESET_CYCLES(LIGHT_CONTROLLER_RESET_CYCLES)) chk (.sys_clk(sys_clk), .nrst(nrst),
  .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
  .controllerHaltedFlag(controllerHaltedFlag),
  .asyncAdvanceIrqEnable(asyncAdvanceIrqEnable),
  .asyncAdvanceStatusClr(asyncAdvanceStatusClr),
  .asyncAdvanceStatus(asyncAdvanceStatus), .uframeTick(uframeTick),
  .scheduleEvictDone(scheduleEvictDone), .doorbellRequest(doorbellRequest),
  .lightResetActive(lightResetActive), .asyncAdvanceIrq(asyncAdvanceIrq));

`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the usb host command controls block
// assumes the design and uhcc_cmd_chk are compiled alongside
`timescale 1ns/1ps
`default_nettype none

module tb;
  // short light reset keeps the run small
  localparam int LR = 3;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0, regRdEn = 1'b0, regRdValid;
  logic [31:0] regWrData = 32'h0, regRdData, d;
  logic controllerHaltedFlag = 1'b1, asyncAdvanceIrqEnable = 1'b0;
  logic asyncAdvanceStatusClr = 1'b0, asyncAdvanceStatus;
  logic uframeTick = 1'b0, scheduleEvictDone = 1'b0;
  logic doorbellRequest, lightResetActive, asyncAdvanceIrq;
  int nMismatch = 0;
  int testsRun = 0;
  logic [7:0] codes [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h02, 8'h04};

  always #25 sys_clk = ~sys_clk;

  uhcc_cmd #(.LIGHT_CONTROLLER_RESET_CYCLES(LR)) dut (.sys_clk, .nrst, .regAddr, .regWrEn,
    .regRdEn, .regWrData, .regRdData, .regRdValid, .controllerHaltedFlag,
    .asyncAdvanceIrqEnable, .asyncAdvanceStatusClr, .asyncAdvanceStatus,
    .uframeTick, .scheduleEvictDone, .doorbellRequest, .lightResetActive,
    .asyncAdvanceIrq);

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a; regWrData <= v; regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    chk("valid", {31'h0, regRdValid}, 32'h1);
    v = regRdData;
  endtask : rd

  task automatic tick;
    @(posedge sys_clk) uframeTick <= 1'b1;
    @(posedge sys_clk) uframeTick <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic endSim;
    $display("mismatches %0d checks %0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : endSim

  // ==========================================================
  // scenarios
  task automatic tReset;
    rd(8'h20, d); chk("cmd reset", d, 32'h0008_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, d); chk("unmapped", d, 32'h0);
  endtask : tReset

  task automatic tThreshold;
    foreach (codes[i]) begin
      // reserved bits stay zero; out-of-block low bits must read zero
      wr(8'h20, 32'h0000_003F | {8'h00, codes[i], 16'h0});
      rd(8'h20, d); chk("itc", d, {8'h00, codes[i], 16'h0});
    end
    @(posedge sys_clk) controllerHaltedFlag <= 1'b0;
    // running: the field is only written back unchanged
    wr(8'h20, 32'h0004_0000);
    rd(8'h20, d); chk("itc running", d, 32'h0004_0000);
  endtask : tThreshold

  task automatic tDoorbell;
    // schedule taken as active while the doorbell is rung
    wr(8'h20, 32'h0004_0040);
    chk("bell req", {31'h0, doorbellRequest}, 32'h1);
    @(posedge sys_clk) scheduleEvictDone <= 1'b1;
    @(posedge sys_clk) scheduleEvictDone <= 1'b0;
    #1;
    chk("status", {30'h0, asyncAdvanceStatus, doorbellRequest}, 32'h2);
    rd(8'h20, d); chk("bell bit", d, 32'h0004_0040);
    repeat (8) tick();
    chk("irq masked", {31'h0, asyncAdvanceIrq}, 32'h0);
    @(posedge sys_clk) asyncAdvanceIrqEnable <= 1'b1;
    repeat (4) tick();
    chk("irq", {31'h0, asyncAdvanceIrq}, 32'h1);
    @(posedge sys_clk) asyncAdvanceStatusClr <= 1'b1;
    @(posedge sys_clk) asyncAdvanceStatusClr <= 1'b0;
    @(posedge sys_clk) scheduleEvictDone <= 1'b1;
    @(posedge sys_clk) scheduleEvictDone <= 1'b0;
    #1;
    chk("irq clear", {30'h0, asyncAdvanceStatus, asyncAdvanceIrq}, 32'h0);
  endtask : tDoorbell

  task automatic tLight;
    @(posedge sys_clk) controllerHaltedFlag <= 1'b1;
    wr(8'h20, 32'h0004_0080);
    chk("lr active", {31'h0, lightResetActive}, 32'h1);
    rd(8'h20, d); chk("lr busy", {31'h0, d[7]}, 32'h1);
    repeat (LR + 3) @(posedge sys_clk);
    #1;
    chk("lr done", {31'h0, lightResetActive}, 32'h0);
    rd(8'h20, d); chk("lr cmd", d, 32'h0008_0000);
  endtask : tLight

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    tReset();
    tThreshold();
    tDoorbell();
    tLight();
    endSim();
  end

  initial begin
    #(50 * 4000);
    nMismatch++;
    endSim();
  end
endmodule : tb

`default_nettype wire
